// [inc/mesim_params.svh]
`ifndef MESIM_PARAMS_SVH
`define MESIM_PARAMS_SVH

// Register offsets on the serial register port
`define MESIM_OFS_STICKY 12'h403
`define MESIM_OFS_LIVE 12'h404
`define MESIM_OFS_MASK 12'h405
`define MESIM_OFS_PHIDLE 12'h407

// Live event state field positions
`define MESIM_LIVE_NEWSAMPLE 16
`define MESIM_LIVE_IDLE_LSB 10
`define MESIM_LIVE_SIGN_LSB 6
`define MESIM_LIVE_SWELL_LSB 3
`define MESIM_LIVE_DIP_LSB 0

// Sticky flag and mask field positions
`define MESIM_STICKY_IDLE_LSB 0
`define MESIM_EVT_PWR 18
`define MESIM_EVT_RMSHALF 19
`define MESIM_EVT_RMS1012 20
`define MESIM_EVT_THDPF 21
`define MESIM_EVT_TRIG 22
`define MESIM_EVT_BUFFULL 23
`define MESIM_EVT_MISMATCH 24
`define MESIM_EVT_TEMP 25

// Writable mask bits and reset values
`define MESIM_MASK_WRITABLE 32'h03ff_ffff
`define MESIM_RST_WORD 32'h0000_0000
`define MESIM_RST_PHIDLE 18'h0_0000

`endif

// [inc/mesim_pkg.sv]
`include "mesim_params.svh"

package mesim_pkg;

    // One register word
    typedef logic [31:0] mesim_word_t;

    // Register port address
    typedef logic [11:0] mesim_addr_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        REG_NONE = 3'b000,
        REG_STICKY = 3'b001,
        REG_LIVE = 3'b010,
        REG_MASK = 3'b011,
        REG_PHIDLE = 3'b100
    } mesim_reg_e;

endpackage : mesim_pkg

// [design/mesim_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_edge_det #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] sigIn,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall,
    output logic [WIDTH-1:0] change
);

    logic [WIDTH-1:0] prev_r;

    // Previous sample of each input
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prev_r <= '0;
        end else begin
            prev_r <= sigIn;
        end
    end

    // Transition pulses, one cycle each
    assign rise = sigIn & ~prev_r;
    assign fall = ~sigIn & prev_r;
    assign change = sigIn ^ prev_r;

endmodule : mesim_edge_det

`default_nettype wire

// [design/mesim_w1c_flags.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_w1c_flags #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] setEvt,
    input wire logic clearWr,
    input wire logic [WIDTH-1:0] clearBits,
    output logic [WIDTH-1:0] flags_r
);

    logic [WIDTH-1:0] flags_nxt;

    // Write one clears; a same-cycle event wins over the clear
    always_comb begin
        flags_nxt = flags_r;
        if (clearWr) begin
            flags_nxt = flags_nxt & ~clearBits;
        end
        flags_nxt = flags_nxt | setEvt;
    end

    // Flag storage
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule : mesim_w1c_flags

`default_nettype wire

// [design/mesim_event_irq.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_event_irq
    import mesim_pkg::*;
(
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regWrData,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Per-phase idle states, bit 0 is phase A
    input wire logic [2:0] fundApparentIdle,
    input wire logic [2:0] fundReactiveIdle,
    input wire logic [2:0] fundActiveIdle,
    input wire logic [2:0] totalApparentIdle,
    input wire logic [2:0] totalReactiveIdle,
    input wire logic [2:0] totalActiveIdle,
    // Sample strobe, energy pulse pins and their signs
    input wire logic newWaveformSample,
    input wire logic energyPulseOut1,
    input wire logic energyPulseOut2,
    input wire logic energyPulseOut3,
    input wire logic energyPulseOut4,
    input wire logic pulse1Positive,
    input wire logic pulse2Positive,
    input wire logic pulse3Positive,
    input wire logic pulse4Positive,
    // Voltage swell and dip conditions
    input wire logic phaseAOvervoltageState,
    input wire logic phaseBOvervoltageState,
    input wire logic phaseCOvervoltageState,
    input wire logic phaseASagState,
    input wire logic phaseBSagState,
    input wire logic phaseCSagState,
    // Metrology event sources
    input wire logic tempResultReady,
    input wire logic summedCurrentAboveThreshold,
    input wire logic resampledBufferFull,
    input wire logic captureSelection,
    input wire logic bufferTriggerEvent,
    input wire logic distortionPfUpdate,
    input wire logic multicycleRmsUpdate,
    input wire logic halfcycleRmsUpdate,
    input wire logic powerAccumUpdate,
    // Interrupt request to the host
    output logic irqRequest
);

    // Address decode shared by the read and write paths
    function automatic mesim_reg_e decodeAddr(input logic [11:0] addr);
        mesim_reg_e sel;
        sel = REG_NONE;
        unique case (addr)
            `MESIM_OFS_STICKY: begin
                sel = REG_STICKY;
            end
            `MESIM_OFS_LIVE: begin
                sel = REG_LIVE;
            end
            `MESIM_OFS_MASK: begin
                sel = REG_MASK;
            end
            `MESIM_OFS_PHIDLE: begin
                sel = REG_PHIDLE;
            end
            default: begin
                sel = REG_NONE;
            end
        endcase
        return sel;
    endfunction : decodeAddr

    // Reset release synchroniser
    logic rstMeta_r;
    logic rstSync_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // Register port decode
    mesim_reg_e wrSel;
    mesim_reg_e rdSel;
    logic stickyClearWr;
    logic maskWr;
    logic liveRead;

    assign wrSel = decodeAddr(regAddr);
    assign rdSel = decodeAddr(regAddr);
    assign stickyClearWr = regWrite && (wrSel == REG_STICKY);
    assign maskWr = regWrite && (wrSel == REG_MASK);
    assign liveRead = regRead && (rdSel == REG_LIVE);

    // Idle states gathered, six kinds of three phases
    logic [17:0] idleAll;
    logic [17:0] idleChange;
    logic [5:0] idleKindChange;
    logic [5:0] allOutOfIdle;

    assign idleAll = {fundApparentIdle, fundReactiveIdle, fundActiveIdle,
                      totalApparentIdle, totalReactiveIdle, totalActiveIdle};

    // Entry and exit of idle for each phase
    mesim_edge_det #(
        .WIDTH(18)
    ) u_idle_edges (
        .clk(mclk),
        .rstN(rstSync_r),
        .sigIn(idleAll),
        .rise(),
        .fall(),
        .change(idleChange)
    );

    // Per kind: any phase changed, and all phases out of idle
    genvar k;
    generate
        for (k = 0; k < 6; k++) begin : g_kind
            assign idleKindChange[k] = |idleChange[3*k +: 3];
            assign allOutOfIdle[k] = ~|idleAll[3*k +: 3];
        end
    endgenerate

    // Per-phase idle snapshot taken on every change
    logic [17:0] phaseIdle_r;

    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            phaseIdle_r <= `MESIM_RST_PHIDLE;
        end else if (|idleKindChange) begin
            phaseIdle_r <= idleAll;
        end
    end

    // Snapshot widened to a register word, upper bits zero
    mesim_word_t phaseIdleWord;

    assign phaseIdleWord = {14'h0, phaseIdle_r};

    // Energy pulse pins, falling edge marks an issued pulse
    logic [3:0] pulsePins;
    logic [3:0] pulseSigns;
    logic [3:0] pulseIssued;
    logic [3:0] pulseSign_r;

    assign pulsePins = {energyPulseOut4, energyPulseOut3, energyPulseOut2, energyPulseOut1};
    assign pulseSigns = {pulse4Positive, pulse3Positive, pulse2Positive, pulse1Positive};

    mesim_edge_det #(
        .WIDTH(4)
    ) u_pulse_edges (
        .clk(mclk),
        .rstN(rstSync_r),
        .sigIn(pulsePins),
        .rise(),
        .fall(pulseIssued),
        .change()
    );

    // Sign of last pulse, held between pulses
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_sign
            always_ff @(posedge mclk or negedge rstSync_r) begin
                if (!rstSync_r) begin
                    pulseSign_r[p] <= 1'b0;
                end else if (pulseIssued[p]) begin
                    pulseSign_r[p] <= pulseSigns[p];
                end
            end
        end
    endgenerate

    // New sample flag, set by the sample strobe, cleared by reading
    logic newSample_r;

    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            newSample_r <= 1'b0;
        end else if (newWaveformSample) begin
            newSample_r <= 1'b1;
        end else if (liveRead) begin
            newSample_r <= 1'b0;
        end
    end

    // Voltage condition groups, phase C in the top bit
    logic [2:0] swellStates;
    logic [2:0] sagStates;

    assign swellStates = {phaseCOvervoltageState, phaseBOvervoltageState, phaseAOvervoltageState};
    assign sagStates = {phaseCSagState, phaseBSagState, phaseASagState};

    // Live event state word
    mesim_word_t liveWord;

    always_comb begin
        liveWord = `MESIM_RST_WORD;
        liveWord[`MESIM_LIVE_NEWSAMPLE] = newSample_r;
        liveWord[`MESIM_LIVE_IDLE_LSB +: 6] = allOutOfIdle;
        liveWord[`MESIM_LIVE_SIGN_LSB +: 4] = pulseSign_r;
        liveWord[`MESIM_LIVE_SWELL_LSB +: 3] = swellStates;
        liveWord[`MESIM_LIVE_DIP_LSB +: 3] = sagStates;
    end

    // Summed-current comparison outcome changes
    logic mismatchChange;

    mesim_edge_det #(
        .WIDTH(1)
    ) u_mismatch_edge (
        .clk(mclk),
        .rstN(rstSync_r),
        .sigIn(summedCurrentAboveThreshold),
        .rise(),
        .fall(),
        .change(mismatchChange)
    );

    // Buffer full counts only for resampled capture
    logic bufFullEvt;

    assign bufFullEvt = resampledBufferFull && !captureSelection;

    // Event sources placed at their flag positions
    mesim_word_t eventSet;

    always_comb begin
        eventSet = `MESIM_RST_WORD;
        eventSet[`MESIM_STICKY_IDLE_LSB +: 6] = idleKindChange;
        eventSet[`MESIM_EVT_TEMP] = tempResultReady;
        eventSet[`MESIM_EVT_MISMATCH] = mismatchChange;
        eventSet[`MESIM_EVT_BUFFULL] = bufFullEvt;
        eventSet[`MESIM_EVT_TRIG] = bufferTriggerEvent;
        eventSet[`MESIM_EVT_THDPF] = distortionPfUpdate;
        eventSet[`MESIM_EVT_RMS1012] = multicycleRmsUpdate;
        eventSet[`MESIM_EVT_RMSHALF] = halfcycleRmsUpdate;
        eventSet[`MESIM_EVT_PWR] = powerAccumUpdate;
    end

    // Sticky flags, write one to clear
    mesim_word_t stickyFlags;

    mesim_w1c_flags #(
        .WIDTH(32)
    ) u_sticky (
        .clk(mclk),
        .rstN(rstSync_r),
        .setEvt(eventSet),
        .clearWr(stickyClearWr),
        .clearBits(regWrData),
        .flags_r(stickyFlags)
    );

    // Interrupt enable register, reserved bits kept at zero
    mesim_word_t intEnable_r;

    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            intEnable_r <= `MESIM_RST_WORD;
        end else if (maskWr) begin
            intEnable_r <= regWrData & `MESIM_MASK_WRITABLE;
        end
    end

    // Flags that are both set and enabled
    mesim_word_t irqPending;

    assign irqPending = stickyFlags & intEnable_r;

    // Interrupt request from enabled sticky flags
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= |irqPending;
        end
    end

    // Read data mux
    mesim_word_t rdMux;

    always_comb begin
        rdMux = `MESIM_RST_WORD;
        unique case (rdSel)
            REG_STICKY: begin
                rdMux = stickyFlags;
            end
            REG_LIVE: begin
                rdMux = liveWord;
            end
            REG_MASK: begin
                rdMux = intEnable_r;
            end
            REG_PHIDLE: begin
                rdMux = phaseIdleWord;
            end
            REG_NONE: begin
                rdMux = `MESIM_RST_WORD;
            end
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            regRdData <= `MESIM_RST_WORD;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                regRdData <= rdMux;
            end
        end
    end

endmodule : mesim_event_irq

`default_nettype wire

// [testbench/mesim_host.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_host (
    input wire logic mclk,
    input wire logic [31:0] regRdData,
    input wire logic regRdValid,
    output logic [11:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [31:0] regWrData
);
    // Idle register port at time zero
    initial begin
        regAddr = 12'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 32'h0;
    end

    // One word write, bus inverted once released
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge mclk);
        regWrite = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask : wr

    // One word read, answer taken one cycle after the request
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(negedge mclk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge mclk);
        regRead = 1'b0;
        regAddr = ~a;
        d = (regRdValid === 1'b1) ? regRdData : 32'hx;
    endtask : rd
endmodule : mesim_host

`default_nettype wire

// [testbench/mesim_event_irq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_event_irq_assertions (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [11:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regWrData,
    input wire logic [31:0] regRdData,
    input wire logic regRdValid,
    input wire logic [2:0] fundApparentIdle,
    input wire logic [2:0] fundReactiveIdle,
    input wire logic [2:0] fundActiveIdle,
    input wire logic [2:0] totalApparentIdle,
    input wire logic [2:0] totalReactiveIdle,
    input wire logic [2:0] totalActiveIdle,
    input wire logic phaseASagState,
    input wire logic phaseBSagState,
    input wire logic phaseCSagState,
    input wire logic tempResultReady,
    input wire logic irqRequest
);
    logic [1:0] rstSh_r;
    logic [31:0] maskSh_r;
    logic [17:0] idleAll;

    // All idle inputs as one word
    assign idleAll = {fundApparentIdle, fundReactiveIdle, fundActiveIdle,
        totalApparentIdle, totalReactiveIdle, totalActiveIdle};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Delay of the internal reset release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            rstSh_r <= 2'h0;
        else
            rstSh_r <= {rstSh_r[0], 1'b1};
    end

    // Shadow of the writable mask bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            maskSh_r <= 32'h0;
        else if (rstSh_r[1] && regWrite && regAddr == 12'h405)
            maskSh_r <= regWrData & 32'h03ff_ffff;
    end

    // Read request and its answer
    sequence readOf(a);
        regRead && regAddr == a ##1 regRdValid;
    endsequence

    rd_valid_a: assert property (rstSh_r[1] && regRead |=> regRdValid)
        else $error("read answer missing");
    live_dip_a: assert property (readOf(12'h404) |->
        regRdData[2:0] == $past({phaseCSagState, phaseBSagState, phaseASagState})) else $error("dip bits wrong");
    live_idle_a: assert property (readOf(12'h404) |-> regRdData[15:10] == $past({~|fundApparentIdle,
        ~|fundReactiveIdle, ~|fundActiveIdle, ~|totalApparentIdle, ~|totalReactiveIdle, ~|totalActiveIdle}))
        else $error("live idle bits wrong");
    live_rsvd_a: assert property (readOf(12'h404) |-> regRdData[31:17] == 15'h0)
        else $error("live reserved bits set");
    mask_read_a: assert property (readOf(12'h405) |-> regRdData == $past(maskSh_r))
        else $error("mask readback wrong");
    sticky_set_a: assert property (rstSh_r[1] && $changed(fundReactiveIdle) ##1 readOf(12'h403) |->
        regRdData[4]) else $error("idle change flag not set");
    sticky_clear_a: assert property (regWrite && regAddr == 12'h403 && regWrData[4:0] == 5'h1f &&
        $stable(idleAll) ##1 $stable(idleAll) ##1 ($stable(idleAll) and readOf(12'h403)) |->
        regRdData[4:0] == 5'h0) else $error("idle flags not cleared");
    irq_raise_a: assert property (rstSh_r[1] && tempResultReady ##1 maskSh_r[25] |=> irqRequest)
        else $error("interrupt not raised");
    irq_masked_a: assert property (maskSh_r == 32'h0 |=> !irqRequest)
        else $error("interrupt with all masked");
endmodule : mesim_event_irq_assertions

bind mesim_event_irq mesim_event_irq_assertions mesim_event_irq_assertions_inst (.*);

`default_nettype wire

// [testbench/mesim_event_irq_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module mesim_event_irq_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] regAddr;
    logic regWrite;
    logic regRead;
    logic [31:0] regWrData;
    logic [31:0] regRdData;
    logic regRdValid;
    logic irqRequest;
    logic [17:0] idle = 18'h0;
    logic [3:0] pin = 4'h0;
    logic [3:0] pos = 4'h0;
    logic [3:0] sgn = 4'h0;
    logic [2:0] swl = 3'h0;
    logic [2:0] dip = 3'h0;
    logic [7:0] evt = 8'h0;
    logic newS = 1'b0;
    logic capSel = 1'b0;
    logic [31:0] got;
    int fails = 0;
    int checks = 0;

    always #10 mclk = ~mclk;

    mesim_host mesim_host_inst (.mclk(mclk), .regRdData(regRdData), .regRdValid(regRdValid), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData));

    mesim_event_irq mesim_event_irq_inst (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .fundApparentIdle(idle[17:15]), .fundReactiveIdle(idle[14:12]), .fundActiveIdle(idle[11:9]),
        .totalApparentIdle(idle[8:6]), .totalReactiveIdle(idle[5:3]), .totalActiveIdle(idle[2:0]),
        .newWaveformSample(newS), .energyPulseOut1(pin[0]), .energyPulseOut2(pin[1]), .energyPulseOut3(pin[2]),
        .energyPulseOut4(pin[3]), .pulse1Positive(pos[0]), .pulse2Positive(pos[1]), .pulse3Positive(pos[2]),
        .pulse4Positive(pos[3]), .phaseAOvervoltageState(swl[0]), .phaseBOvervoltageState(swl[1]),
        .phaseCOvervoltageState(swl[2]), .phaseASagState(dip[0]), .phaseBSagState(dip[1]), .phaseCSagState(dip[2]),
        .tempResultReady(evt[7]), .summedCurrentAboveThreshold(evt[6]), .resampledBufferFull(evt[5]),
        .captureSelection(capSel), .bufferTriggerEvent(evt[4]), .distortionPfUpdate(evt[3]),
        .multicycleRmsUpdate(evt[2]), .halfcycleRmsUpdate(evt[1]), .powerAccumUpdate(evt[0]), .irqRequest(irqRequest));

    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Expected live event word
    function automatic logic [31:0] liveExp(input logic ns);
        logic [5:0] nl;
        for (int g = 0; g < 6; g++) nl[g] = ~|idle[3*g +: 3];
        return {15'h0, ns, nl, sgn, swl, dip};
    endfunction : liveExp

    task automatic tk(input int n);
        repeat (n) @(negedge mclk);
    endtask : tk

    task automatic end_of_test;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // Hang guard
    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    // Main sequence
    initial begin
        got = $urandom(32'heeec);
        tk(20);
        reset_n = 1'b1;
        tk(3);
        host_reads: begin
            mesim_host_inst.wr(12'h406, 32'hffff_ffff);
            mesim_host_inst.wr(12'h404, 32'hffff_ffff);
            mesim_host_inst.wr(12'h405, 32'hffff_ffff);
            mesim_host_inst.rd(12'h403, got); chk(got, 32'h0);
            mesim_host_inst.rd(12'h404, got); chk(got, liveExp(1'b0));
            mesim_host_inst.rd(12'h405, got); chk(got, 32'h03ff_ffff);
            mesim_host_inst.rd(12'h406, got); chk(got, 32'h0);
            mesim_host_inst.rd(12'h407, got); chk(got, 32'h0);
            mesim_host_inst.wr(12'h405, 32'h0);
        end
        $display("test registers done");
        repeat (8) begin
            @(negedge mclk);
            idle = 18'($urandom);
            swl = 3'($urandom);
            dip = 3'($urandom);
            mesim_host_inst.rd(12'h404, got); chk(got, liveExp(1'b0));
        end
        $display("test live done");
        mesim_host_inst.wr(12'h403, 32'h3f);
        mesim_host_inst.rd(12'h403, got); chk(got, 32'h0);
        for (int g = 0; g < 6; g++) begin
            @(negedge mclk);
            idle[3*g + $urandom_range(2)] ^= 1'b1;
            mesim_host_inst.rd(12'h403, got); chk(got, 32'h1 << g);
            mesim_host_inst.rd(12'h407, got); chk(got, {14'h0, idle});
            mesim_host_inst.wr(12'h403, 32'h1 << g);
            mesim_host_inst.rd(12'h403, got); chk(got, 32'h0);
        end
        $display("test idle flags done");
        for (int k = 0; k < 8; k++) begin
            @(negedge mclk);
            pin[k%4] = 1'b1;
            pos[k%4] = 1'($urandom);
            @(negedge mclk);
            pin[k%4] = 1'b0;
            sgn[k%4] = pos[k%4];
            @(negedge mclk);
            pos[k%4] = ~pos[k%4];
            pin[k%4] = 1'b1;
            mesim_host_inst.rd(12'h404, got); chk(got, liveExp(1'b0));
        end
        $display("test pulse signs done");
        for (int i = 0; i < 8; i++) begin
            mesim_host_inst.wr(12'h405, 32'h1 << (18 + i));
            @(negedge mclk);
            evt[i] = 1'b1;
            @(negedge mclk);
            if (i != 6)
                evt[i] = 1'b0;
            tk(2);
            chk({31'h0, irqRequest}, 32'h1);
            mesim_host_inst.rd(12'h403, got); chk(got, 32'h1 << (18 + i));
            mesim_host_inst.wr(12'h403, got);
            tk(3);
            chk({31'h0, irqRequest}, 32'h0);
        end
        mesim_host_inst.wr(12'h405, 32'h1 << 23);
        @(negedge mclk);
        capSel = 1'b1;
        evt[5] = 1'b1;
        evt[7] = 1'b1;
        @(negedge mclk);
        evt[5] = 1'b0;
        evt[7] = 1'b0;
        tk(3);
        chk({31'h0, irqRequest}, 32'h0);
        mesim_host_inst.rd(12'h403, got); chk(got, 32'h1 << 25);
        mesim_host_inst.wr(12'h403, got);
        $display("test interrupts done");
        @(negedge mclk);
        newS = 1'b1;
        @(negedge mclk);
        newS = 1'b0;
        tk(1);
        mesim_host_inst.rd(12'h404, got); chk(got, liveExp(1'b1));
        mesim_host_inst.rd(12'h404, got); chk(got, liveExp(1'b0));
        $display("test new sample done");
        end_of_test();
    end
endmodule : mesim_event_irq_tb_top

`default_nettype wire
